// ==== pkg/cgr_params.svh ====
`ifndef CGR_PARAMS_SVH
`define CGR_PARAMS_SVH

// serial access
`define CGR_SLAVE_ADDR      8'hD2
`define CGR_CMD_BYTE_BIT    7
`define CGR_BLOCK_COUNT     8'h0F
`define CGR_FIRST_BYTE      4'h1
`define CGR_LAST_BYTE       4'h9

// power-up values, bytes 1..9 (bytes 7 and 8 upper nibble come from id parameters)
`define CGR_RST_B1          8'h85
`define CGR_RST_B2          8'hFF
`define CGR_RST_B3          8'hFF
`define CGR_RST_B4          8'hFF
`define CGR_RST_B5          8'h00
`define CGR_RST_B6          8'h00
`define CGR_RST_B8_LOW      4'h3
`define CGR_RST_B9          8'h25

// bits that software may change; all others hold their power-up value
`define CGR_WMASK_B1        8'h7E
`define CGR_WMASK_B2        8'hC0
`define CGR_WMASK_B4        8'h7F
`define CGR_WMASK_B6        8'h28
`define CGR_WMASK_B8        8'h03
`define CGR_WMASK_B9        8'h1F

// field positions
`define CGR_B1_MAIN_DIR     6
`define CGR_B1_AUX_DIR      5
`define CGR_B1_CFG_HI       4
`define CGR_B1_CFG_LO       1
`define CGR_B2_REF_EN       7
`define CGR_B2_USB_EN       6
`define CGR_B4_STORAGE_EN   6
`define CGR_B4_SERIAL_EN    5
`define CGR_B4_VIDEO96_EN   4
`define CGR_B4_CPU1_EN      3
`define CGR_B4_CPU0_EN      2
`define CGR_B4_MAIN_SS_EN   1
`define CGR_B4_AUX_SS_EN    0
`define CGR_B6_REF_SLEW     5
`define CGR_B6_V27_SLEW     3
`define CGR_B8_V27_NSS_EN   1
`define CGR_B8_V27_SS_EN    0
`define CGR_B9_TEST_SEL     4
`define CGR_B9_TEST_ENTRY   3
`define CGR_B9_AMP_HI       2

`endif

// ==== pkg/cgr_pkg.sv ====
package cgr_pkg;

    typedef enum logic [6:0] {
        CGR_IDLE = 7'b000_0001,
        CGR_ADDR = 7'b000_0010,
        CGR_CMD  = 7'b000_0100,
        CGR_WR   = 7'b000_1000,
        CGR_ACK  = 7'b001_0000,
        CGR_RD   = 7'b010_0000,
        CGR_MACK = 7'b100_0000
    } cgr_state_e;

    typedef logic [7:0] cgr_byte_t;

endpackage : cgr_pkg

// ==== src/cgr_in_sync.sv ====
module cgr_in_sync #(
    parameter int          WIDTH = 2,
    parameter logic [1:0]  RST   = 2'h3
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset,
    input  wire logic             i_clk_en,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_level
);

    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] next_level;

    // a bit only moves once the second and third stage agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (s2[i] == s3[i]) ? s3[i] : o_level[i];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            s1      <= RST[WIDTH-1:0];
            s2      <= RST[WIDTH-1:0];
            s3      <= RST[WIDTH-1:0];
            o_level <= RST[WIDTH-1:0];
        end else if (i_clk_en) begin
            s1      <= i_async;
            s2      <= s1;
            s3      <= s2;
            o_level <= next_level;
        end
    end

endmodule : cgr_in_sync

// ==== src/cgr_regs.sv ====
// Notes on behaviour
// - Byte 1 bits 6 and 5 pick down (0) or center (1) spread for main and aux synth, default 0.
// - The aux synth config field in byte 1 bits 4:1 applies only while the source select is 0.
// - Byte 2 bit 7 enables the crystal buffer output and powers up as 1.
// - Byte 2 bit 6 enables the 48 MHz bus clock output and powers up as 1.
// - Byte 4 bits 6:2 enable storage, serial, video 96, processor 1 and 0 clocks, default 1.
// - Byte 6 bit 5 is the middle reference slew bit, 0 high slew and 1 low slew.
// - Byte 6 bit 3 is the middle 27 MHz slew bit, 0 high slew and 1 low slew.
// - Byte 8 bits 1 and 0 enable the non-spread and spread 27 MHz video outputs, default 1.
// - Byte 9 bit 4 picks test behaviour, 0 tri-states all outputs, 1 drives reference over N.
// - Byte 9 bit 3 enters the selected test mode when 1, default 0.
// - Byte 9 bits 2:0 set differential amplitude, 0.30 V plus 0.10 V per step, default 101.
// - Access is over the two-wire bus at address 11010010, command bit 7 picks byte access.
// - Every register holds its power-up value before the first access.
`include "cgr_params.svh"
module cgr_regs #(
    parameter logic [3:0] REV_CODE    = 4'h3,  // arbitrary value
    parameter logic [3:0] VENDOR_CODE = 4'h5,  // arbitrary value
    parameter logic [3:0] PART_CODE   = 4'h6   // arbitrary value
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset,
    input  wire logic       i_clk_en,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_serial_link_clock_source_select,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    output logic            o_main_synth_spread_direction,
    output logic            o_aux_synth_spread_direction,
    output logic [3:0]      o_aux_synth_config_field,
    output logic            o_aux_synth_config_active,
    output logic            o_crystal_buffer_enable,
    output logic            o_usb_48mhz_enable,
    output logic            o_storage_link_output_enable,
    output logic            o_serial_link_output_enable,
    output logic            o_video_96mhz_output_enable,
    output logic            o_processor_clock_1_enable,
    output logic            o_processor_clock_0_enable,
    output logic            o_main_synth_spread_enable,
    output logic            o_aux_synth_spread_enable,
    output logic            o_crystal_buffer_slew_middle_bit,
    output logic            o_video_27mhz_slew_middle_bit,
    output logic            o_video_27mhz_nonspread_enable,
    output logic            o_video_27mhz_spread_enable,
    output logic            o_test_outputs_tristate,
    output logic            o_test_outputs_ref_div,
    output logic [2:0]      o_differential_amplitude_code
);

    localparam logic [7:0] SLAVE_ADDR = `CGR_SLAVE_ADDR;

    function automatic cgr_pkg::cgr_byte_t reg_mask(input logic [3:0] idx);
        case (idx)
            4'h1:    reg_mask = `CGR_WMASK_B1;
            4'h2:    reg_mask = `CGR_WMASK_B2;
            4'h4:    reg_mask = `CGR_WMASK_B4;
            4'h6:    reg_mask = `CGR_WMASK_B6;
            4'h8:    reg_mask = `CGR_WMASK_B8;
            4'h9:    reg_mask = `CGR_WMASK_B9;
            default: reg_mask = 8'h00;
        endcase
    endfunction : reg_mask

    function automatic cgr_pkg::cgr_byte_t reg_reset(input logic [3:0] idx);
        case (idx)
            4'h1:    reg_reset = `CGR_RST_B1;
            4'h2:    reg_reset = `CGR_RST_B2;
            4'h3:    reg_reset = `CGR_RST_B3;
            4'h4:    reg_reset = `CGR_RST_B4;
            4'h6:    reg_reset = `CGR_RST_B6;
            4'h7:    reg_reset = {REV_CODE, VENDOR_CODE};
            4'h8:    reg_reset = {PART_CODE, `CGR_RST_B8_LOW};
            4'h9:    reg_reset = `CGR_RST_B9;
            default: reg_reset = `CGR_RST_B5;
        endcase
    endfunction : reg_reset

    logic [1:0]            line;
    logic                  scl_d;
    logic                  sda_d;
    cgr_pkg::cgr_state_e   state,    next_state;
    cgr_pkg::cgr_state_e   after,    next_after;
    logic [3:0]            bit_cnt,  next_bit_cnt;
    cgr_pkg::cgr_byte_t    shreg,    next_shreg;
    logic [6:0]            ptr,      next_ptr;
    logic                  block,    next_block;
    logic                  first,    next_first;
    logic                  sda_oe,   next_sda_oe;
    cgr_pkg::cgr_byte_t    regs      [1:9];
    cgr_pkg::cgr_byte_t    next_regs [1:9];
    logic                  in_range;
    logic                  wr_fire;
    cgr_pkg::cgr_byte_t    tx_byte;

    cgr_in_sync #(.WIDTH(2), .RST(2'h3)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_async   ({i_scl, i_sda}),
        .o_level   (line)
    );

    wire scl_rise = line[1] & ~scl_d;
    wire scl_fall = ~line[1] & scl_d;
    wire start_c  = line[1] & scl_d & sda_d & ~line[0];
    wire stop_c   = line[1] & scl_d & ~sda_d & line[0];
    wire byte_end = scl_fall && (bit_cnt == 4'd8);

    always_comb begin
        in_range = (ptr >= {3'h0, `CGR_FIRST_BYTE}) && (ptr <= {3'h0, `CGR_LAST_BYTE});
        tx_byte  = (block && first) ? `CGR_BLOCK_COUNT : (in_range ? regs[ptr[3:0]] : 8'h00);
        wr_fire  = i_clk_en && (state == cgr_pkg::CGR_WR) && byte_end && !first && in_range;
        next_state   = state;
        next_after   = after;
        next_bit_cnt = bit_cnt;
        next_shreg   = shreg;
        next_ptr     = ptr;
        next_block   = block;
        next_first   = first;
        next_sda_oe  = sda_oe;
        for (int i = 1; i <= 9; i++) begin
            next_regs[i] = regs[i];
        end
        if (scl_rise && state != cgr_pkg::CGR_RD && state != cgr_pkg::CGR_MACK) begin
            next_shreg = {shreg[6:0], line[0]};
        end
        if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'd1;
        end
        if (start_c) begin
            // a repeated start keeps the pointer set by the command
            next_state   = cgr_pkg::CGR_ADDR;
            next_bit_cnt = 4'd0;
            next_sda_oe  = 1'b0;
        end else if (stop_c) begin
            next_state  = cgr_pkg::CGR_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                cgr_pkg::CGR_ADDR: begin
                    if (byte_end) begin
                        next_bit_cnt = 4'd0;
                        if (shreg[7:1] == SLAVE_ADDR[7:1]) begin
                            next_sda_oe = 1'b1;
                            next_state  = cgr_pkg::CGR_ACK;
                            next_after  = shreg[0] ? cgr_pkg::CGR_RD : cgr_pkg::CGR_CMD;
                        end else begin
                            next_state = cgr_pkg::CGR_IDLE;
                        end
                    end
                end
                cgr_pkg::CGR_CMD: begin
                    if (byte_end) begin
                        next_bit_cnt = 4'd0;
                        next_block   = !shreg[`CGR_CMD_BYTE_BIT];
                        next_first   = !shreg[`CGR_CMD_BYTE_BIT];
                        next_ptr     = shreg[`CGR_CMD_BYTE_BIT] ? shreg[6:0] : 7'h00;
                        next_sda_oe  = 1'b1;
                        next_state   = cgr_pkg::CGR_ACK;
                        next_after   = cgr_pkg::CGR_WR;
                    end
                end
                cgr_pkg::CGR_WR: begin
                    if (byte_end) begin
                        next_bit_cnt = 4'd0;
                        next_sda_oe  = 1'b1;
                        next_state   = cgr_pkg::CGR_ACK;
                        // block writes lead with a count byte that only gets acknowledged
                        if (first) begin
                            next_first = 1'b0;
                        end else begin
                            next_ptr = ptr + 7'd1;
                        end
                        if (wr_fire) begin
                            next_regs[ptr[3:0]] = (shreg & reg_mask(ptr[3:0]))
                                | (regs[ptr[3:0]] & ~reg_mask(ptr[3:0]));
                        end
                    end
                end
                cgr_pkg::CGR_ACK, cgr_pkg::CGR_MACK: begin
                    if (state == cgr_pkg::CGR_MACK && scl_rise && line[0]) begin
                        next_state = cgr_pkg::CGR_IDLE;
                    end else if (scl_fall && (state == cgr_pkg::CGR_MACK
                                 || after == cgr_pkg::CGR_RD)) begin
                        next_bit_cnt = 4'd0;
                        next_shreg   = tx_byte;
                        next_sda_oe  = !tx_byte[7];
                        next_state   = cgr_pkg::CGR_RD;
                        if (first) begin
                            next_first = 1'b0;
                        end else begin
                            next_ptr = ptr + 7'd1;
                        end
                    end else if (scl_fall) begin
                        next_bit_cnt = 4'd0;
                        next_sda_oe  = 1'b0;
                        next_state   = after;
                    end
                end
                cgr_pkg::CGR_RD: begin
                    if (byte_end) begin
                        next_sda_oe = 1'b0;
                        next_bit_cnt = 4'd0;
                        next_state  = cgr_pkg::CGR_MACK;
                    end else if (scl_fall) begin
                        next_sda_oe = !shreg[6];
                        next_shreg  = {shreg[6:0], 1'b0};
                    end
                end
                default: begin
                    next_state = cgr_pkg::CGR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            scl_d   <= 1'b1;
            sda_d   <= 1'b1;
            state   <= cgr_pkg::CGR_IDLE;
            after   <= cgr_pkg::CGR_IDLE;
            bit_cnt <= 4'd0;
            shreg   <= 8'h00;
            ptr     <= 7'h00;
            block   <= 1'b0;
            first   <= 1'b0;
            sda_oe  <= 1'b0;
            for (int i = 1; i <= 9; i++) begin
                regs[i] <= reg_reset(4'(i));
            end
        end else if (i_clk_en) begin
            scl_d   <= line[1];
            sda_d   <= line[0];
            state   <= next_state;
            after   <= next_after;
            bit_cnt <= next_bit_cnt;
            shreg   <= next_shreg;
            ptr     <= next_ptr;
            block   <= next_block;
            first   <= next_first;
            sda_oe  <= next_sda_oe;
            for (int i = 1; i <= 9; i++) begin
                regs[i] <= next_regs[i];
            end
        end
    end

    // derived controls, registered so every output leaves a flip-flop
    logic next_cfg_active;
    logic next_tristate;
    logic next_ref_div;

    always_comb begin
        next_cfg_active = !i_serial_link_clock_source_select;
        next_tristate   = regs[9][`CGR_B9_TEST_ENTRY] && !regs[9][`CGR_B9_TEST_SEL];
        next_ref_div    = regs[9][`CGR_B9_TEST_ENTRY] && regs[9][`CGR_B9_TEST_SEL];
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_sda_out                 <= 1'b0;
            o_aux_synth_config_active <= 1'b0;
            o_test_outputs_tristate   <= 1'b0;
            o_test_outputs_ref_div    <= 1'b0;
        end else if (i_clk_en) begin
            o_sda_out                 <= 1'b0;
            o_aux_synth_config_active <= next_cfg_active;
            o_test_outputs_tristate   <= next_tristate;
            o_test_outputs_ref_div    <= next_ref_div;
        end
    end

    assign o_sda_oe                         = sda_oe;
    assign o_main_synth_spread_direction    = regs[1][`CGR_B1_MAIN_DIR];
    assign o_aux_synth_spread_direction     = regs[1][`CGR_B1_AUX_DIR];
    assign o_aux_synth_config_field         = regs[1][`CGR_B1_CFG_HI:`CGR_B1_CFG_LO];
    assign o_crystal_buffer_enable          = regs[2][`CGR_B2_REF_EN];
    assign o_usb_48mhz_enable               = regs[2][`CGR_B2_USB_EN];
    assign o_storage_link_output_enable     = regs[4][`CGR_B4_STORAGE_EN];
    assign o_serial_link_output_enable      = regs[4][`CGR_B4_SERIAL_EN];
    assign o_video_96mhz_output_enable      = regs[4][`CGR_B4_VIDEO96_EN];
    assign o_processor_clock_1_enable       = regs[4][`CGR_B4_CPU1_EN];
    assign o_processor_clock_0_enable       = regs[4][`CGR_B4_CPU0_EN];
    assign o_main_synth_spread_enable       = regs[4][`CGR_B4_MAIN_SS_EN];
    assign o_aux_synth_spread_enable        = regs[4][`CGR_B4_AUX_SS_EN];
    assign o_crystal_buffer_slew_middle_bit = regs[6][`CGR_B6_REF_SLEW];
    assign o_video_27mhz_slew_middle_bit    = regs[6][`CGR_B6_V27_SLEW];
    assign o_video_27mhz_nonspread_enable   = regs[8][`CGR_B8_V27_NSS_EN];
    assign o_video_27mhz_spread_enable      = regs[8][`CGR_B8_V27_SS_EN];
    assign o_differential_amplitude_code    = regs[9][`CGR_B9_AMP_HI:0];

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    property p_dir_write;
        wr_fire && ptr == 7'd1 |=> o_main_synth_spread_direction == $past(shreg[6])
            && o_aux_synth_spread_direction == $past(shreg[5]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("spread direction not written");
    property p_cfg_active;
        i_clk_en |=> o_aux_synth_config_active == !$past(i_serial_link_clock_source_select);
    endproperty
    a_cfg_active: assert property (p_cfg_active) else $error("config gate wrong");
    property p_misc_write;
        wr_fire && ptr == 7'd2 |=> {o_crystal_buffer_enable, o_usb_48mhz_enable}
            == $past(shreg[7:6]);
    endproperty
    a_misc_write: assert property (p_misc_write) else $error("byte 2 enables wrong");
    property p_main_write;
        wr_fire && ptr == 7'd4 |=> {o_storage_link_output_enable, o_serial_link_output_enable,
            o_video_96mhz_output_enable, o_processor_clock_1_enable,
            o_processor_clock_0_enable} == $past(shreg[6:2]);
    endproperty
    a_main_write: assert property (p_main_write) else $error("byte 4 enables wrong");
    property p_test_mode;
        i_clk_en |=> o_test_outputs_ref_div == $past(regs[9][4] && regs[9][3]);
    endproperty
    a_test_mode: assert property (p_test_mode) else $error("test mode output wrong");
    property p_amp_write;
        wr_fire && ptr == 7'd9 |=> o_differential_amplitude_code == $past(shreg[2:0]);
    endproperty
    a_amp_write: assert property (p_amp_write) else $error("amplitude not written");
    property p_ident;
        regs[7] == {REV_CODE, VENDOR_CODE} && regs[8][7:4] == PART_CODE;
    endproperty
    a_ident: assert property (p_ident) else $error("identity bits changed");
    property p_reserved;
        regs[3] == `CGR_RST_B3 && regs[5] == `CGR_RST_B5
            && (regs[9] & ~`CGR_WMASK_B9) == (`CGR_RST_B9 & ~`CGR_WMASK_B9);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits changed");
    property p_addr_miss;
        i_clk_en && state == cgr_pkg::CGR_ADDR && byte_end && !start_c && !stop_c
            && shreg[7:1] != SLAVE_ADDR[7:1] |=> !o_sda_oe [*2];
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged");
    property p_powerup;
        $past(i_reset) |-> regs[4] == `CGR_RST_B4 && regs[1] == `CGR_RST_B1 && !o_sda_oe;
    endproperty
    a_powerup: assert property (p_powerup) else $error("power-up value wrong");

    c_write: cover property (wr_fire);
    c_read:  cover property (state == cgr_pkg::CGR_RD && byte_end);
    c_test:  cover property (o_test_outputs_tristate);

endmodule : cgr_regs

// ==== verification/cgr_host_model.sv ====
`include "cgr_params.svh"
module cgr_host_model (
    input  wire logic i_sys_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // block transfers run from offset 0: data goes out of here, read bytes land here
    logic [7:0] blk [0:10];
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : tick
    // data moves only while the clock is low, so starts and stops are never faked
    task automatic put_bit(input logic b);
        o_sda_low <= ~b;
        tick(4);
        o_scl <= 1'b1;
        tick(10);
        o_scl <= 1'b0;
        tick(4);
    endtask : put_bit
    // released line floats to the pull-up, never the last driven bit
    task automatic get_bit(output logic b);
        o_sda_low <= 1'b0;
        tick(4);
        o_scl <= 1'b1;
        tick(7);
        b = i_sda;
        tick(3);
        o_scl <= 1'b0;
        tick(4);
    endtask : get_bit
    task automatic start();
        o_sda_low <= 1'b0;
        tick(4);
        o_scl <= 1'b1;
        tick(10);
        o_sda_low <= 1'b1;
        tick(10);
        o_scl <= 1'b0;
        tick(4);
    endtask : start
    task automatic stop();
        o_sda_low <= 1'b1;
        tick(4);
        o_scl <= 1'b1;
        tick(10);
        o_sda_low <= 1'b0;
        tick(10);
    endtask : stop
    task automatic send_byte(input logic [7:0] d, inout logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(a);
        ok = ok & ~a;
    endtask : send_byte
    task automatic byte_write(input logic [6:0] off, input logic [7:0] d,
                              input logic [7:0] addr, output logic ok);
        ok = 1'b1;
        start();
        send_byte(addr, ok);
        send_byte({1'b1, off}, ok);
        send_byte(d, ok);
        stop();
    endtask : byte_write
    task automatic byte_read(input logic [6:0] off, output logic [7:0] d, output logic ok);
        logic b;
        ok = 1'b1;
        start();
        send_byte(`CGR_SLAVE_ADDR, ok);
        send_byte({1'b1, off}, ok);
        start();
        send_byte(`CGR_SLAVE_ADDR | 8'h01, ok);
        for (int i = 0; i < 8; i++) begin
            get_bit(b);
            d = {d[6:0], b};
        end
        put_bit(1'b1);
        stop();
    endtask : byte_read
    task automatic block_write(output logic ok);
        ok = 1'b1;
        start();
        send_byte(`CGR_SLAVE_ADDR, ok);
        send_byte(8'h00, ok);
        send_byte(8'h0A, ok);
        for (int i = 0; i < 10; i++) send_byte(blk[i], ok);
        stop();
    endtask : block_write
    // count byte first, then offsets 0..9; only the last byte gets a no-acknowledge
    task automatic block_read(output logic ok);
        logic b;
        ok = 1'b1;
        start();
        send_byte(`CGR_SLAVE_ADDR, ok);
        send_byte(8'h00, ok);
        start();
        send_byte(`CGR_SLAVE_ADDR | 8'h01, ok);
        for (int n = 0; n <= 10; n++) begin
            for (int i = 0; i < 8; i++) begin
                get_bit(b);
                blk[n] = {blk[n][6:0], b};
            end
            put_bit(n == 10);
        end
        stop();
    endtask : block_read
endmodule : cgr_host_model

// ==== verification/cgr_regs_test.sv ====
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
    $display("[FAIL] t=%0t act=%h exp=%h", $time, (a), (e)); end end
module cgr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] REV  = 4'h3; // arbitrary value
    localparam logic [3:0] VEN  = 4'h5; // arbitrary value
    localparam logic [3:0] PART = 4'h6; // arbitrary value
    logic       i_sys_clk = 1'b0;
    logic       i_reset   = 1'b1;
    logic       sel       = 1'b0;
    logic       en        = 1'b1;
    wire        sda_out;
    logic       scl;
    logic       host_low;
    wire        sda_oe;
    wire        sda_line = ~(host_low | sda_oe);
    wire [24:0] outs;
    logic [7:0] img [0:15];
    logic [7:0] rst_val [1:9] = '{8'h85, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, {REV, VEN},
                                  {PART, 4'h3}, 8'h25};
    logic [7:0] wmask [1:9] = '{8'h7E, 8'hC0, 8'h00, 8'h7F, 8'h00, 8'h28, 8'h00, 8'h03, 8'h1F};
    int         miscompares = 0;
    int         checks = 0;
    always #4 i_sys_clk = ~i_sys_clk;
    cgr_host_model i_cgr_host_model (
        .i_sys_clk (i_sys_clk), .i_sda (sda_line), .o_scl (scl), .o_sda_low (host_low));
    cgr_regs #(.REV_CODE (REV), .VENDOR_CODE (VEN), .PART_CODE (PART)) i_cgr_regs (
        .i_sys_clk                         (i_sys_clk),
        .i_reset                           (i_reset),
        .i_clk_en                          (en),
        .i_scl                             (scl),
        .i_sda                             (sda_line),
        .i_serial_link_clock_source_select (sel),
        .o_sda_out                         (sda_out),
        .o_sda_oe                          (sda_oe),
        .o_main_synth_spread_direction     (outs[24]),
        .o_aux_synth_spread_direction      (outs[23]),
        .o_aux_synth_config_field          (outs[22:19]),
        .o_crystal_buffer_enable           (outs[18]),
        .o_usb_48mhz_enable                (outs[17]),
        .o_storage_link_output_enable      (outs[16]),
        .o_serial_link_output_enable       (outs[15]),
        .o_video_96mhz_output_enable       (outs[14]),
        .o_processor_clock_1_enable        (outs[13]),
        .o_processor_clock_0_enable        (outs[12]),
        .o_main_synth_spread_enable        (outs[11]),
        .o_aux_synth_spread_enable         (outs[10]),
        .o_crystal_buffer_slew_middle_bit  (outs[9]),
        .o_video_27mhz_slew_middle_bit     (outs[8]),
        .o_video_27mhz_nonspread_enable    (outs[7]),
        .o_video_27mhz_spread_enable       (outs[6]),
        .o_test_outputs_tristate           (outs[5]),
        .o_test_outputs_ref_div            (outs[4]),
        .o_differential_amplitude_code     (outs[3:1]),
        .o_aux_synth_config_active         (outs[0])
    );
    function automatic logic [24:0] exp_outs();
        exp_outs = {img[1][6:1], img[2][7:6], img[4][6:0], img[6][5], img[6][3], img[8][1:0],
                    img[9][3] & ~img[9][4], img[9][3] & img[9][4], img[9][2:0], ~sel};
    endfunction : exp_outs
    task automatic report_and_stop();
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input int off, input logic [7:0] v);
        logic ok;
        i_cgr_host_model.byte_write(7'(off), v, 8'hD2, ok);
        `CHK(ok, 1'b1)
        `CHK(sda_out, 1'b0)
        if (off >= 1 && off <= 9) img[off] = (img[off] & ~wmask[off]) | (v & wmask[off]);
        `CHK(outs, exp_outs())
    endtask : wr
    task automatic rd(input int off, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        i_cgr_host_model.byte_read(7'(off), d, ok);
        `CHK(ok, 1'b1)
        `CHK(d, e)
    endtask : rd
    task automatic do_reset();
        i_reset <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        for (int i = 0; i < 16; i++) img[i] = (i >= 1 && i <= 9) ? rst_val[i] : 8'h00;
        `CHK(outs, exp_outs())
    endtask : do_reset
    initial begin
        repeat (100000) @(posedge i_sys_clk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        logic ok;
        do_reset();
        for (int i = 0; i <= 10; i++) rd(i, img[i]);
        // ones then zeros: every writable bit set and cleared, protected bits must hold
        for (int p = 0; p < 2; p++) begin
            for (int i = 1; i <= 9; i++) wr(i, p == 0 ? 8'hFF : 8'h00);
            for (int i = 1; i <= 9; i++) rd(i, img[i]);
        end
        for (int c = 0; c < 8; c++) wr(9, 8'(c));
        wr(9, 8'h08);
        wr(9, 8'h18);
        sel <= 1'b1;
        wr(1, 8'h1E);
        sel <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        `CHK(outs, exp_outs())
        wr(10, 8'hFF);
        rd(10, 8'h00);
        i_cgr_host_model.byte_write(7'h01, 8'h00, 8'hD4, ok);
        `CHK(ok, 1'b0)
        `CHK(outs, exp_outs())
        rd(1, img[1]);
        // a frozen block sees no frame at all, so nothing is acknowledged or written
        en <= 1'b0;
        i_cgr_host_model.byte_write(7'h02, 8'h00, 8'hD2, ok);
        `CHK(ok, 1'b0)
        `CHK(outs, exp_outs())
        en <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            i_cgr_host_model.blk[i] = 8'hA5 ^ 8'(i);
            if (i > 0) img[i] = (img[i] & ~wmask[i]) | (i_cgr_host_model.blk[i] & wmask[i]);
        end
        i_cgr_host_model.block_write(ok);
        `CHK(ok, 1'b1)
        `CHK(outs, exp_outs())
        i_cgr_host_model.block_read(ok);
        `CHK(ok, 1'b1)
        `CHK(i_cgr_host_model.blk[0], 8'h0F)
        for (int i = 0; i <= 9; i++) `CHK(i_cgr_host_model.blk[i + 1], img[i])
        do_reset();
        rd(9, 8'h25);
        report_and_stop();
    end
endmodule : cgr_regs_test
